// ==== hdl/serial_codec_control.v ====
// Serial control logic of an 8-bit ADC plus 8-bit DAC codec
`timescale 1ns/10ps
`default_nettype none
`include "serial_codec_consts.vh"
module serial_codec_control #(
    parameter CONV_CYCLES = `CONV_CYCLES,
    parameter FIFO_DEPTH = `RESULT_FIFO_DEPTH
) (
    input wire ref_clk,
    input wire reset,
    input wire chip_select_n,
    input wire serial_clock,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_oe_n,
    input wire comparator_high,
    input wire input_negative,
    input wire input_over_reference,
    output reg [7:0] sar_trial_code,
    output reg [7:0] dac_code,
    output reg reference_power,
    output reg adc_power,
    output reg dac_power,
    output reg input_select,
    output reg track_hold_hold,
    output reg converting,
    output wire result_valid,
    input wire result_ready,
    output wire [7:0] result_data
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_CTRL = 5'b00010;
    localparam ST_DAC = 5'b00100;
    localparam ST_CONV = 5'b01000;
    localparam ST_SHIFT = 5'b10000;
    localparam [31:0] STEP_CYCLES = (CONV_CYCLES / 8 < 1) ? 1 : CONV_CYCLES / 8;

    reg [2:0] cs_sync;
    reg [2:0] sck_sync;
    reg [1:0] din_sync;
    wire cs_active;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire din_bit;
    assign cs_active = !cs_sync[1];
    assign cs_rise = cs_sync[1] && !cs_sync[2];
    assign sck_rise = sck_sync[1] && !sck_sync[2];
    assign sck_fall = !sck_sync[1] && sck_sync[2];
    assign din_bit = din_sync[1];

    reg [4:0] state;
    reg [7:0] shift_reg;
    reg [2:0] bit_count;
    reg [7:0] control_word;
    reg word_done;
    reg [7:0] dac_input;
    reg [7:0] result_shift;
    reg [3:0] out_count;
    reg [31:0] step_count;
    reg [2:0] sar_bit;
    reg [7:0] sar_result;
    reg sar_done;
    reg fifo_in_valid;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_pop;

    function [7:0] clamp_code;
        input [7:0] code;
        input neg;
        input over;
        begin
            if (neg) begin
                clamp_code = 8'h00;
            end else if (over) begin
                clamp_code = 8'hFF;
            end else begin
                clamp_code = code;
            end
        end
    endfunction

    always @(posedge ref_clk) begin
        if (reset) begin
            cs_sync <= 3'h7;
            sck_sync <= 3'h0;
            din_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], chip_select_n};
            sck_sync <= {sck_sync[1:0], serial_clock};
            din_sync <= {din_sync[0], serial_in};
        end
    end

    // Serial front end and sequencing
    always @(posedge ref_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            shift_reg <= 8'h00;
            bit_count <= 3'h0;
            control_word <= `CW_RESET;
            word_done <= 1'b0;
            dac_input <= `DAC_CODE_RESET;
            dac_code <= `DAC_CODE_RESET;
            reference_power <= 1'b0;
            adc_power <= 1'b0;
            dac_power <= 1'b0;
            input_select <= 1'b0;
            track_hold_hold <= 1'b0;
            converting <= 1'b0;
            step_count <= 32'h0;
            sar_bit <= 3'h7;
            sar_trial_code <= 8'h80;
            sar_result <= 8'h00;
            sar_done <= 1'b0;
            fifo_in_valid <= 1'b0;
            fifo_pop <= 1'b0;
            result_shift <= 8'h00;
            out_count <= 4'h0;
            serial_out <= 1'b0;
            serial_out_oe_n <= 1'b1;
        end else begin
            fifo_in_valid <= 1'b0;
            fifo_pop <= 1'b0;
            serial_out_oe_n <= !cs_active;
            if (cs_rise) begin
                bit_count <= 3'h0;
                if (state == ST_CTRL || state == ST_DAC) begin
                    state <= ST_IDLE;
                end
            end
            // Conversion runs on the fabric clock, not the serial clock
            if (converting) begin
                if (step_count == STEP_CYCLES - 1) begin
                    step_count <= 32'h0;
                    sar_trial_code[sar_bit] <= comparator_high;
                    if (sar_bit != 3'h0) begin
                        sar_trial_code[sar_bit - 3'h1] <= 1'b1;
                        sar_bit <= sar_bit - 3'h1;
                    end else begin
                        converting <= 1'b0;
                        track_hold_hold <= 1'b0;
                        sar_done <= 1'b1;
                        sar_result <= clamp_code({sar_trial_code[7:1], comparator_high},
                            input_negative, input_over_reference);
                    end
                end else begin
                    step_count <= step_count + 32'h1;
                end
            end
            if (sar_done && fifo_in_ready) begin
                fifo_in_valid <= 1'b1;
                sar_done <= 1'b0;
            end
            case (state)
            ST_IDLE: begin
                if (cs_active && sck_rise) begin
                    if (din_bit) begin
                        shift_reg <= 8'h01;
                        bit_count <= 3'h1;
                        state <= ST_CTRL;
                    end
                end
            end
            ST_CTRL: begin
                if (cs_active && sck_rise) begin
                    shift_reg <= {shift_reg[6:0], din_bit};
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == 3'h7) begin
                        control_word <= {shift_reg[6:0], din_bit};
                        word_done <= 1'b1;
                        reference_power <= shift_reg[`CW_REF_PWR_POS - 1];
                        adc_power <= shift_reg[`CW_ADC_PWR_POS - 1];
                        dac_power <= din_bit;
                        input_select <= shift_reg[`CW_INPUT_SEL_POS - 1];
                    end
                end else if (word_done && sck_fall) begin
                    word_done <= 1'b0;
                    bit_count <= 3'h0;
                    if (control_word[`CW_ADC_SEL_POS]) begin
                        track_hold_hold <= 1'b1;
                        converting <= 1'b1;
                        step_count <= 32'h0;
                        sar_bit <= 3'h7;
                        sar_trial_code <= 8'h80;
                    end
                    if (control_word[`CW_DAC_SEL_POS]) begin
                        state <= ST_DAC;
                    end else if (control_word[`CW_ADC_SEL_POS]) begin
                        state <= ST_CONV;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
            end
            ST_DAC: begin
                if (cs_active && sck_rise) begin
                    dac_input <= {dac_input[6:0], din_bit};
                    bit_count <= bit_count + 3'h1;
                    if (bit_count == 3'h7) begin
                        dac_code <= {dac_input[6:0], din_bit};
                        if (!control_word[`CW_REPEAT_POS]) begin
                            state <= control_word[`CW_ADC_SEL_POS] ? ST_CONV : ST_IDLE;
                        end
                    end
                end
            end
            ST_CONV: begin
                // Result waits until the conversion is fully done
                if (fifo_out_valid && !converting && !sar_done) begin
                    // MSB stands before the first rise; falls bring the rest
                    serial_out <= fifo_out_data[7];
                    result_shift <= {fifo_out_data[6:0], 1'b0};
                    fifo_pop <= 1'b1;
                    out_count <= 4'h0;
                    state <= ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (cs_active && sck_fall) begin
                    serial_out <= result_shift[7];
                    result_shift <= {result_shift[6:0], 1'b0};
                    out_count <= out_count + 4'h1;
                    if (out_count == 4'h7) begin
                        if (control_word[`CW_REPEAT_POS]) begin
                            track_hold_hold <= 1'b1;
                            converting <= 1'b1;
                            step_count <= 32'h0;
                            sar_bit <= 3'h7;
                            sar_trial_code <= 8'h80;
                            state <= ST_CONV;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end else if (cs_active && sck_rise && control_word[`CW_REPEAT_POS] && din_bit
                    && out_count == 4'h0) begin
                    // A new start bit reconfigures in continuous mode
                    shift_reg <= 8'h01;
                    bit_count <= 3'h1;
                    state <= ST_CTRL;
                end
            end
            default: state <= ST_IDLE;
            endcase
        end
    end

    result_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_result_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(sar_result),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop || result_ready),
        .out_data(fifo_out_data)
    );
    assign result_valid = fifo_out_valid;
    assign result_data = fifo_out_data;
endmodule
`default_nettype wire

// ==== hdl/serial_codec_consts.vh ====
// Constants for the serial codec control block
`ifndef SERIAL_CODEC_CONSTS_VH
`define SERIAL_CODEC_CONSTS_VH
`define CW_START_POS 7
`define CW_DAC_SEL_POS 6
`define CW_ADC_SEL_POS 5
`define CW_INPUT_SEL_POS 4
`define CW_REPEAT_POS 3
`define CW_REF_PWR_POS 2
`define CW_ADC_PWR_POS 1
`define CW_DAC_PWR_POS 0
`define CW_RESET 8'h00
`define DAC_CODE_RESET 8'h00
`define CLK_PERIOD_PS 4000
`define CONV_TIME_NS 36000
`define CONV_CYCLES ((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define SAR_STEP_CYCLES (`CONV_CYCLES / 8)
`define RESULT_FIFO_DEPTH 4
`endif

// ==== hdl/result_fifo.v ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire ref_clk,
    input wire reset,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/serial_codec_control_sva.sv ====
// Assertion checker for the serial codec control block
`timescale 1ns/10ps
`default_nettype none
module serial_codec_control_sva #(
    parameter CONV_CYCLES = 80
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic serial_out,
    input wire logic serial_out_oe_n,
    input wire logic input_negative,
    input wire logic input_over_reference,
    input wire logic [7:0] dac_code,
    input wire logic reference_power,
    input wire logic adc_power,
    input wire logic dac_power,
    input wire logic input_select,
    input wire logic track_hold_hold,
    input wire logic converting,
    input wire logic result_valid,
    input wire logic [7:0] result_data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [15:0] conv_len;
    // Cycles spent converting so far
    always @(posedge ref_clk) begin
        if (reset || !converting) conv_len <= 16'h0000;
        else conv_len <= conv_len + 16'h0001;
    end
    sequence desel_run;
        chip_select_n [*5];
    endsequence
    sequence conv_end;
        $fell(converting);
    endsequence
    a_oe_off_desel: assert property (desel_run |-> serial_out_oe_n)
        else $error("output driven while deselected");
    a_dac_quiet_desel: assert property (desel_run |=> $stable(dac_code))
        else $error("dac code moved while deselected");
    a_ctrl_quiet_desel: assert property (desel_run |=> $stable({reference_power, adc_power, dac_power, input_select}))
        else $error("control bits moved while deselected");
    a_hold_in_conv: assert property (converting |-> track_hold_hold)
        else $error("tracking during conversion");
    a_conv_time: assert property (conv_end |-> (conv_len >= CONV_CYCLES - 8) && (conv_len <= CONV_CYCLES + 8))
        else $error("conversion length wrong");
    a_track_after: assert property (conv_end |-> ##[0:2] !track_hold_hold)
        else $error("no return to tracking");
    a_out_quiet_conv: assert property (converting && $past(converting) |-> $stable(serial_out))
        else $error("result bit moved during conversion");
    a_clamp_low: assert property ($rose(result_valid) && input_negative |-> result_data == 8'h00)
        else $error("negative input not zero code");
    a_clamp_high: assert property ($rose(result_valid) && input_over_reference |-> result_data == 8'hFF)
        else $error("overrange input not full code");
endmodule
`default_nettype wire

// ==== verif/spi_host_model.sv ====
// Host serial master model driving the codec pins
`timescale 1ns/10ps
`default_nettype none
module spi_host_model #(
    parameter int HALF = 10
) (
    input wire logic ref_clk,
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    output logic [7:0] rx_byte,
    output logic rx_done
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        rx_byte = 8'h00;
        rx_done = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Data set while clock low, result sampled on the rise
    task automatic xfer(input logic [7:0] tx, input logic rd);
        tick(1);
        cs_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            tick(HALF);
            sclk = 1'b1;
            rx_byte[i] = sdo;
            tick(HALF);
            sclk = 1'b0;
        end
        rx_done = rd;
        tick(1);
        rx_done = 1'b0;
    endtask
    task automatic release_bus();
        tick(HALF);
        cs_n = 1'b1;
        sdi = ~sdi;
        tick(4 * HALF);
    endtask
endmodule
`default_nettype wire

// ==== verif/serial_codec_control_tb.sv ====
// Testbench for the serial codec control block
`timescale 1ns/10ps
`default_nettype none
module serial_codec_control_tb;
    localparam int CONV = 80;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic input_negative = 1'b0;
    logic input_over_reference = 1'b0;
    logic result_ready = 1'b0;
    logic [7:0] target = 8'h00;
    logic [31:0] lfsr = 32'h7755;
    logic [7:0] exp_q[$];
    int miscompares = 0;
    int samples_checked = 0;
    wire chip_select_n, serial_clock, serial_in, serial_out, serial_out_oe_n, result_valid, rx_done;
    wire reference_power, adc_power, dac_power, input_select, track_hold_hold, converting;
    wire [7:0] sar_trial_code, dac_code, result_data, rx_byte;
    wire line_out = serial_out_oe_n ? ~serial_out : serial_out;
    wire comparator_high = (sar_trial_code <= target);
    serial_codec_control #(.CONV_CYCLES(CONV), .FIFO_DEPTH(4)) dut_u (.ref_clk(ref_clk), .reset(reset),
        .chip_select_n(chip_select_n), .serial_clock(serial_clock), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n), .comparator_high(comparator_high),
        .input_negative(input_negative), .input_over_reference(input_over_reference),
        .sar_trial_code(sar_trial_code), .dac_code(dac_code), .reference_power(reference_power),
        .adc_power(adc_power), .dac_power(dac_power), .input_select(input_select),
        .track_hold_hold(track_hold_hold), .converting(converting), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data));
    spi_host_model #(.HALF(10)) host_u (.ref_clk(ref_clk), .cs_n(chip_select_n), .sclk(serial_clock),
        .sdi(serial_in), .sdo(line_out), .rx_byte(rx_byte), .rx_done(rx_done));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic conclude();
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Word, conversion wait, then optional read of the result
    task automatic convert(input logic [7:0] w, input logic rd);
        target = rnd();
        exp_q.push_back(input_negative ? 8'h00 : input_over_reference ? 8'hFF : target);
        host_u.xfer(w, 1'b0);
        tick(CONV + 40);
        if (rd) host_u.xfer(8'h00, 1'b1);
    endtask
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge rx_done) check(rx_byte, exp_q.pop_front());
    always @(posedge ref_clk) if (result_valid === 1'b1 && result_ready) check(result_data, exp_q.pop_front());
    initial begin
        #(50000 * 4);
        miscompares++;
        conclude();
    end
    initial begin
        logic [7:0] d;
        d = 8'h00;
        repeat (12) @(posedge ref_clk);
        #1 reset = 1'b0;
        tick(4);
        check({5'h00, reference_power, adc_power, dac_power}, 8'h00);
        check(dac_code, 8'h00);
        host_u.xfer(8'h00, 1'b0);
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            host_u.xfer(8'hC0 | 8'(i), 1'b0);
            host_u.xfer(d, 1'b0);
            tick(3);
            check(dac_code, d);
            check({5'h00, reference_power, adc_power, dac_power}, 8'(i));
            host_u.release_bus();
        end
        host_u.xfer(8'h87, 1'b0);
        host_u.xfer(8'h5A, 1'b0);
        tick(3);
        check(dac_code, d);
        check({5'h00, reference_power, adc_power, dac_power}, 8'h07);
        host_u.release_bus();
        host_u.xfer(8'h96, 1'b0);
        tick(3);
        check({7'h00, input_select}, 8'h01);
        tick(900);
        for (int m = 0; m < 3; m++) begin
            input_negative = (m == 1);
            input_over_reference = (m == 2);
            convert(m == 0 ? 8'hB6 : 8'hA6, 1'b1);
            tick(6);
            check({7'h00, converting}, 8'h00);
            host_u.release_bus();
        end
        input_negative = 1'b0;
        input_over_reference = 1'b0;
        check({7'h00, input_select}, 8'h00);
        result_ready = 1'b1;
        convert(8'hA6, 1'b0);
        result_ready = 1'b0;
        check({7'h00, result_valid}, 8'h00);
        host_u.xfer(8'h00, 1'b0);
        host_u.release_bus();
        convert(8'hAE, 1'b0);
        target = rnd();
        exp_q.push_back(target);
        host_u.xfer(8'h00, 1'b1);
        tick(6);
        check({7'h00, converting}, 8'h01);
        tick(CONV + 40);
        host_u.xfer(8'h00, 1'b1);
        tick(4);
        conclude();
    end
endmodule
bind serial_codec_control serial_codec_control_sva #(.CONV_CYCLES(CONV_CYCLES)) sva_u (.ref_clk(ref_clk),
    .reset(reset), .chip_select_n(chip_select_n), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .input_negative(input_negative), .input_over_reference(input_over_reference), .dac_code(dac_code),
    .reference_power(reference_power), .adc_power(adc_power), .dac_power(dac_power),
    .input_select(input_select), .track_hold_hold(track_hold_hold), .converting(converting),
    .result_valid(result_valid), .result_data(result_data));
`default_nettype wire
